// >>> pkg/cirt_pkg.sv
package cirt_pkg;

  // opcode patterns: whole words or upper 6, 7 or 8 bits of the instruction word
  localparam logic [15:0] CIRT_NOP_WORD      = 16'h0000;
  localparam logic [15:0] CIRT_RETURN_WORD   = 16'h0002;
  localparam logic [15:0] CIRT_SLEEP_WORD    = 16'h0003;
  localparam logic [15:0] CIRT_RETFIRQ_WORD  = 16'h0005;
  localparam logic [6:0]  CIRT_SUBWB_HI7     = 7'h01;  // 0000 001d
  localparam logic [6:0]  CIRT_SUBW_HI7      = 7'h02;  // 0000 010d
  localparam logic [6:0]  CIRT_XORF_HI7      = 7'h06;  // 0000 110d
  localparam logic [6:0]  CIRT_RRC_HI7       = 7'h0c;  // 0001 100d
  localparam logic [6:0]  CIRT_RLC_HI7       = 7'h0d;  // 0001 101d
  localparam logic [6:0]  CIRT_SWAP_HI7      = 7'h0e;  // 0001 110d
  localparam logic [6:0]  CIRT_RRN_HI7       = 7'h10;  // 0010 000d
  localparam logic [6:0]  CIRT_RLN_HI7       = 7'h11;  // 0010 001d
  localparam logic [6:0]  CIRT_SETALL_HI7    = 7'h15;  // 0010 101d
  localparam logic [7:0]  CIRT_TSTZ_HI8      = 8'h33;
  localparam logic [7:0]  CIRT_SUBLIT_HI8    = 8'hb2;
  localparam logic [7:0]  CIRT_RETLIT_HI8    = 8'hb6;
  localparam logic [7:0]  CIRT_XORLIT_HI8    = 8'hb4;
  localparam logic [5:0]  CIRT_LATRD_HI6     = 6'h28;  // 1010 00tx
  localparam logic [5:0]  CIRT_LATWR_HI6     = 6'h29;  // 1010 01tx
  localparam logic [5:0]  CIRT_TBLRD_HI6     = 6'h2a;  // 1010 10ti
  localparam logic [5:0]  CIRT_TBLWR_HI6     = 6'h2b;  // 1010 11ti

  // field positions
  localparam int CIRT_DEST_BIT = 8;
  localparam int CIRT_T_BIT    = 9;
  localparam int CIRT_I_BIT    = 8;
  localparam int CIRT_GID_BIT  = 4;  // global irq disable in cpu status
  localparam logic [7:0] CIRT_PCL_ADDR = 8'h02;
  localparam logic [7:0] CIRT_ALL_ONES = 8'hff;

  // reset values
  localparam logic [7:0]  CIRT_W_RST      = 8'h00;
  localparam logic [15:0] CIRT_LATCH_RST  = 16'h0000;
  localparam logic [15:0] CIRT_PTR_RST    = 16'h0000;

  // arithmetic flags
  typedef struct packed {
    logic overflow;
    logic z;
    logic digit_carry;
    logic c;
  } cirt_flags_type;

  // data file access request
  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] data;
  } cirt_file_wr_type;

  // program memory access
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] data;
  } cirt_pmem_req_type;

  typedef enum logic [1:0] {
    CIRT_ALU_SUB,
    CIRT_ALU_PASS
  } cirt_alu_op_type;

endpackage

// >>> rtl/cirt_alu.sv
`timescale 1ns/1ps
module cirt_alu
  import cirt_pkg::*;
(
  // operands
  input  wire logic [7:0]     a,
  input  wire logic [7:0]     b,
  input  wire logic           borrow_in,
  // result
  output logic [7:0]          diff,
  output cirt_flags_type      flags
);

  logic [8:0] full_d;
  logic [4:0] low_d;

  // a - b - borrow as a + ~b + !borrow; carry set means no borrow
  always_comb begin
    full_d = {1'b0, a} + {1'b0, ~b} + {8'h00, ~borrow_in};
    low_d  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, ~borrow_in};
    diff   = full_d[7:0];
    flags.c  = full_d[8];
    flags.digit_carry = low_d[4];
    flags.z  = (full_d[7:0] == 8'h00);
    flags.overflow = (a[7] != b[7]) && (full_d[7] != a[7]);
  end

endmodule

// >>> rtl/cirt_core.sv
`timescale 1ns/1ps
// Behaviour
// - return from irq pops stack top to pc, clears irq disable, 2 cycles
// - return literal loads w with literal, pc from stack top, 2 cycles
// - subroutine return pops stack into pc, 2 cycles, no flags
// - rotate left through carry; bit 7 to carry, carry to bit 0
// - rotate left plain; bit 7 wraps to bit 0, no flags
// - rotate right through carry; bit 0 to carry, carry to bit 7
// - rotate right plain; bit 0 wraps to bit 7, no flags
// - destination bit 0 sends result to w, 1 back to file
// - set file writes all ones to file, also w when dest is 0
// - sleep clears power down, sets timeout, clears watchdog, halts
// - literal minus w into w, updating all four arithmetic flags
// - file minus w routed by dest, updating four flags
// - file minus w minus borrow routed by dest, four flags
// - nibble swap of file routed by dest, flags unchanged
// - table read: latch byte to file, load latch, bump pointer
// - table write: file to latch byte, latch to memory, bump pointer
// - on-chip table write programs until an enabled interrupt arrives
// - irq disable set: end write without vector; clear: ack after
// - only enabled interrupts end programming; their flags are cleared
// - latch read and latch write move one byte in one cycle
// - test skip discards next instruction when file is zero
// - xor with literal or file, only zero flag changes
module cirt_core
  import cirt_pkg::*;
#(
  parameter logic [15:0] ONCHIP_TOP = 16'h07ff  // last on-chip address
)(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // instruction issue
  input  wire logic              insn_valid,
  input  wire logic [15:0]       insn,
  output logic                   insn_ready,
  // data file read and write
  input  wire logic [7:0]        file_rdata,
  output cirt_file_wr_type       file_wr,
  // cpu state kept outside
  input  wire logic [15:0]       stack_top,
  input  wire logic [7:0]        cpu_status_reg,
  input  cirt_flags_type         flags_in,
  // control outputs to the pc, stack and status logic
  output logic                   pc_load,
  output logic [15:0]            pc_value,
  output logic                   stack_pop,
  output logic                   skip_next,
  output logic                   flags_we,
  output cirt_flags_type         flags_out,
  output logic                   clear_irq_disable,
  output logic                   power_down_flag_clr,
  output logic                   timeout_flag_set,
  output logic                   watchdog_clear,
  output logic                   sleep_halt,
  // program memory
  output cirt_pmem_req_type      pmem,
  input  wire logic [15:0]       pmem_rdata,
  // interrupts that may end a long write
  input  wire logic [2:0]        irq_flags,
  input  wire logic [2:0]        irq_mask_en,
  output logic [2:0]             irq_flag_clr,
  output logic                   irq_vector_ok,
  // observed state
  output logic [7:0]             working_reg,
  output logic [15:0]            table_latch,
  output logic [15:0]            table_pointer
);

  typedef enum logic [2:0] {
    ST_EXEC, ST_SECOND, ST_THIRD, ST_PROGRAM, ST_SLEEP
  } cirt_state_type;

  cirt_state_type state_r, state_nxt;
  logic [7:0]     w_r, w_nxt;
  logic [15:0]    latch_r, latch_nxt;
  logic [15:0]    ptr_r, ptr_nxt;
  logic [15:0]    ir_r, ir_nxt;

  logic [7:0]     sub_a, sub_b, sub_diff;
  logic           sub_bin;
  cirt_flags_type sub_flags;
  logic [7:0]     res;
  logic           to_file, to_w;
  logic [2:0]     ending_irq;

  // byte selection of the latch, used by two opcodes
  function automatic logic [7:0] latch_byte(input logic [15:0] l,
                                            input logic t);
    latch_byte = t ? l[15:8] : l[7:0];
  endfunction

  function automatic logic [15:0] latch_put(input logic [15:0] l,
                                            input logic t,
                                            input logic [7:0] v);
    latch_put = t ? {v, l[7:0]} : {l[15:8], v};
  endfunction

  function automatic logic zero8(input logic [7:0] v);
    zero8 = (v == 8'h00);
  endfunction

  cirt_alu u_alu (
    .a         (sub_a),
    .b         (sub_b),
    .borrow_in (sub_bin),
    .diff      (sub_diff),
    .flags     (sub_flags)
  );

  ////////////////////////////////////////////////////////////////////////
  // subtractor operands: literal form swaps file for the literal
  always_comb begin
    sub_a   = (insn[15:8] == CIRT_SUBLIT_HI8) ? insn[7:0] : file_rdata;
    sub_b   = w_r;
    // carry set means no borrow, so subtract-with-borrow takes !c
    sub_bin = (insn[15:9] == CIRT_SUBWB_HI7) ? ~flags_in.c : 1'b0;
  end

  assign ending_irq  = irq_flags & irq_mask_en;
  assign working_reg   = w_r;
  assign table_latch   = latch_r;
  assign table_pointer = ptr_r;
  assign insn_ready    = (state_r == ST_EXEC);

  ////////////////////////////////////////////////////////////////////////
  // decode and execute; one pass per cycle
  always_comb begin
    state_nxt = state_r;
    w_nxt     = w_r;
    latch_nxt = latch_r;
    ptr_nxt   = ptr_r;
    ir_nxt    = ir_r;
    file_wr   = '0;
    pmem      = '0;
    pc_load   = 1'b0;
    pc_value  = stack_top;
    stack_pop = 1'b0;
    skip_next = 1'b0;
    flags_we  = 1'b0;
    flags_out = flags_in;
    clear_irq_disable   = 1'b0;
    power_down_flag_clr = 1'b0;
    timeout_flag_set    = 1'b0;
    watchdog_clear      = 1'b0;
    sleep_halt          = 1'b0;
    irq_flag_clr        = 3'b000;
    irq_vector_ok       = 1'b0;
    res     = file_rdata;
    to_file = 1'b0;
    to_w    = 1'b0;
    case (state_r)
      ST_EXEC: begin
        if (insn_valid) begin
          ir_nxt = insn;
          // nop and unknown words fall through untouched
          if (insn == CIRT_RETURN_WORD) begin
            stack_pop = 1'b1;
            pc_load   = 1'b1;
            state_nxt = ST_SECOND;
          end else if (insn == CIRT_RETFIRQ_WORD) begin
            stack_pop = 1'b1;
            pc_load   = 1'b1;
            clear_irq_disable = 1'b1;
            state_nxt = ST_SECOND;
          end else if (insn[15:8] == CIRT_RETLIT_HI8) begin
            w_nxt     = insn[7:0];
            stack_pop = 1'b1;
            pc_load   = 1'b1;
            state_nxt = ST_SECOND;
          end else if (insn == CIRT_SLEEP_WORD) begin
            power_down_flag_clr = 1'b1;
            timeout_flag_set    = 1'b1;
            watchdog_clear      = 1'b1;
            state_nxt           = ST_SLEEP;
          end else if (insn[15:8] == CIRT_SUBLIT_HI8) begin
            w_nxt     = sub_diff;
            flags_we  = 1'b1;
            flags_out = sub_flags;
          end else if (insn[15:8] == CIRT_XORLIT_HI8) begin
            w_nxt       = w_r ^ insn[7:0];
            flags_we    = 1'b1;
            flags_out.z = zero8(w_r ^ insn[7:0]);
          end else if (insn[15:8] == CIRT_TSTZ_HI8) begin
            if (zero8(file_rdata)) begin
              skip_next = 1'b1;
              state_nxt = ST_SECOND;
            end
          end else if (insn[15:10] == CIRT_LATRD_HI6) begin
            file_wr = '{1'b1, insn[7:0],
                        latch_byte(latch_r, insn[CIRT_T_BIT])};
          end else if (insn[15:10] == CIRT_LATWR_HI6) begin
            latch_nxt = latch_put(latch_r, insn[CIRT_T_BIT],
                                  file_rdata);
          end else if (insn[15:10] == CIRT_TBLRD_HI6) begin
            file_wr = '{1'b1, insn[7:0],
                        latch_byte(latch_r, insn[CIRT_T_BIT])};
            pmem.rd   = 1'b1;
            pmem.addr = ptr_r;
            state_nxt = ST_SECOND;
          end else if (insn[15:10] == CIRT_TBLWR_HI6) begin
            latch_nxt = latch_put(latch_r, insn[CIRT_T_BIT],
                                  file_rdata);
            state_nxt = ST_SECOND;
          end else begin
            // single-operand file ops with a destination bit
            to_file = insn[CIRT_DEST_BIT];
            to_w    = ~insn[CIRT_DEST_BIT];
            case (insn[15:9])
              CIRT_SUBW_HI7, CIRT_SUBWB_HI7: begin
                res       = sub_diff;
                flags_we  = 1'b1;
                flags_out = sub_flags;
              end
              CIRT_XORF_HI7: begin
                res         = file_rdata ^ w_r;
                flags_we    = 1'b1;
                flags_out.z = zero8(file_rdata ^ w_r);
              end
              CIRT_RLC_HI7: begin
                res         = {file_rdata[6:0], flags_in.c};
                flags_we    = 1'b1;
                flags_out.c = file_rdata[7];
              end
              CIRT_RRC_HI7: begin
                res         = {flags_in.c, file_rdata[7:1]};
                flags_we    = 1'b1;
                flags_out.c = file_rdata[0];
              end
              CIRT_RLN_HI7:
                res = {file_rdata[6:0], file_rdata[7]};
              CIRT_RRN_HI7:
                res = {file_rdata[0], file_rdata[7:1]};
              CIRT_SWAP_HI7:
                res = {file_rdata[3:0], file_rdata[7:4]};
              CIRT_SETALL_HI7: begin
                res     = CIRT_ALL_ONES;
                to_file = 1'b1;
              end
              default: begin
                to_file = 1'b0;
                to_w    = 1'b0;
              end
            endcase
            if (to_file)
              file_wr = '{1'b1, insn[7:0], res};
            if (to_w)
              w_nxt = res;
          end
        end
      end
      ST_SECOND: begin
        // second cycle of two-cycle ops; table ops act here
        state_nxt = ST_EXEC;
        if (ir_r[15:10] == CIRT_TBLRD_HI6) begin
          latch_nxt = pmem_rdata;
          if (ir_r[CIRT_I_BIT])
            ptr_nxt = ptr_r + 16'h0001;
          if (ir_r[7:0] == CIRT_PCL_ADDR)
            state_nxt = ST_THIRD;  // pc low target costs a cycle more
        end else if (ir_r[15:10] == CIRT_TBLWR_HI6) begin
          pmem.wr   = 1'b1;
          pmem.addr = ptr_r;
          pmem.data = latch_r;
          if (ptr_r <= ONCHIP_TOP) begin
            state_nxt = ST_PROGRAM;
          end else begin
            if (ir_r[CIRT_I_BIT])
              ptr_nxt = ptr_r + 16'h0001;
            irq_flag_clr = ending_irq;  // short writes clear too
          end
        end
      end
      ST_THIRD:
        state_nxt = ST_EXEC;
      ST_PROGRAM: begin
        // hold the write strobe until an enabled interrupt ends it
        pmem.wr   = 1'b1;
        pmem.addr = ptr_r;
        pmem.data = latch_r;
        if (ending_irq != 3'b000) begin
          irq_flag_clr  = ending_irq;
          irq_vector_ok = ~cpu_status_reg[CIRT_GID_BIT];
          if (ir_r[CIRT_I_BIT])
            ptr_nxt = ptr_r + 16'h0001;
          state_nxt = ST_EXEC;
        end
      end
      ST_SLEEP: begin
        // wake-up belongs to the oscillator logic; reset leaves here
        sleep_halt = 1'b1;
      end
      default:
        state_nxt = ST_EXEC;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= ST_EXEC;
      w_r     <= CIRT_W_RST;
      latch_r <= CIRT_LATCH_RST;
      ptr_r   <= CIRT_PTR_RST;
      ir_r    <= CIRT_NOP_WORD;
    end else begin
      state_r <= state_nxt;
      w_r     <= w_nxt;
      latch_r <= latch_nxt;
      ptr_r   <= ptr_nxt;
      ir_r    <= ir_nxt;
    end
  end

endmodule

// >>> testbench/cirt_mem.sv
`timescale 1ns/1ps
module cirt_mem
  import cirt_pkg::*;
(
  // clock
  input  wire logic        clk,
  // data file side
  input  wire logic [7:0]  faddr,
  input  cirt_file_wr_type file_wr,
  output logic [7:0]       file_rdata,
  // program memory side
  input  cirt_pmem_req_type pmem,
  output logic [15:0]      pmem_rdata = 16'h0000
);
  logic [7:0] mem [256];

  // seeded file contents so every address holds a distinct value
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i * 37 + 5);
    end
  end

  assign file_rdata = mem[faddr];

  // a word is valid only in the cycle after rd; otherwise it toggles so a
  // late sample never looks like good data
  always @(posedge clk) begin
    if (file_wr.we) begin
      mem[file_wr.addr] <= file_wr.data;
    end
    pmem_rdata <= pmem.rd ? ~pmem.addr : ~pmem_rdata;
  end
endmodule

// >>> testbench/cirt_core_chk.sv
`timescale 1ns/1ps
module cirt_core_chk
  import cirt_pkg::*;
(
  // clock and reset
  input wire logic         clk,
  input wire logic         reset,
  // instruction issue
  input wire logic         insn_valid,
  input wire logic [15:0]  insn,
  input wire logic         insn_ready,
  // file and stack
  input wire logic [7:0]   file_rdata,
  input cirt_file_wr_type  file_wr,
  input wire logic [15:0]  stack_top,
  // control outputs
  input wire logic         pc_load,
  input wire logic [15:0]  pc_value,
  input wire logic         stack_pop,
  input wire logic         skip_next,
  input wire logic         flags_we,
  input wire logic         clear_irq_disable,
  input wire logic         power_down_flag_clr,
  input wire logic         timeout_flag_set,
  input wire logic         watchdog_clear,
  input wire logic         sleep_halt,
  // program memory and pointer
  input cirt_pmem_req_type pmem,
  input wire logic [15:0]  table_pointer
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // an instruction is taken only where both sides agree
  wire acc = insn_valid && insn_ready;

  a_ret_pop: assert property (
    pc_load |-> stack_pop && pc_value == stack_top)
    else $error("pc not loaded from stack top");
  a_irq_return: assert property (
    acc && insn == CIRT_RETFIRQ_WORD |-> clear_irq_disable && pc_load
      ##1 !insn_ready) else $error("irq return wrong");
  a_nop_idle: assert property (
    acc && insn == CIRT_NOP_WORD |-> !file_wr.we && !flags_we && !pc_load
      ##1 insn_ready) else $error("nop not idle");
  a_swap_nibble: assert property (
    acc && insn[15:9] == CIRT_SWAP_HI7 && insn[8] |-> file_wr.we &&
      !flags_we && file_wr.data == {file_rdata[3:0], file_rdata[7:4]})
    else $error("swap result wrong");
  a_set_ones: assert property (
    acc && insn[15:9] == CIRT_SETALL_HI7 |-> file_wr.we && !flags_we &&
      file_wr.data == CIRT_ALL_ONES && file_wr.addr == insn[7:0])
    else $error("set file wrong");
  a_skip_zero: assert property (
    acc && insn[15:8] == CIRT_TSTZ_HI8 |-> !flags_we &&
      skip_next == (file_rdata == 8'h00)) else $error("skip wrong");
  a_sleep_halt: assert property (
    acc && insn == CIRT_SLEEP_WORD |-> power_down_flag_clr &&
      timeout_flag_set && watchdog_clear ##1 sleep_halt [*3])
    else $error("sleep wrong");
  a_tblrd_addr: assert property (
    acc && insn[15:10] == CIRT_TBLRD_HI6 |-> pmem.rd &&
      pmem.addr == table_pointer) else $error("table read addr wrong");

  c_long_write: cover property (pmem.wr ##1 pmem.wr ##1 pmem.wr);
  c_skip: cover property (skip_next);
  c_sleep: cover property (acc && insn == CIRT_SLEEP_WORD);
endmodule

bind cirt_core cirt_core_chk u_chk (
  .clk(clk), .reset(reset), .insn_valid(insn_valid), .insn(insn),
  .insn_ready(insn_ready), .file_rdata(file_rdata), .file_wr(file_wr),
  .stack_top(stack_top), .pc_load(pc_load), .pc_value(pc_value),
  .stack_pop(stack_pop), .skip_next(skip_next), .flags_we(flags_we),
  .clear_irq_disable(clear_irq_disable),
  .power_down_flag_clr(power_down_flag_clr),
  .timeout_flag_set(timeout_flag_set), .watchdog_clear(watchdog_clear),
  .sleep_halt(sleep_halt), .pmem(pmem), .table_pointer(table_pointer));

// >>> testbench/cirt_core_tb.sv
`timescale 1ns/1ps
module cirt_core_tb;
  import cirt_pkg::*;
  logic              clk = 0, reset = 1, insn_valid = 0;
  logic [15:0]       insn = 0, stack_top = 0;
  logic [7:0]        cpu_status_reg = 0, file_rdata, working_reg;
  logic [2:0]        irq_flags = 0, irq_mask_en = 0, irq_flag_clr;
  cirt_flags_type    flags_in = 0, flags_out, s_fl, fl = 0;
  cirt_file_wr_type  file_wr;
  cirt_pmem_req_type pmem, s_pm, s_pm2;
  logic              insn_ready, pc_load, stack_pop, skip_next, flags_we;
  logic              clear_irq_disable, power_down_flag_clr, sleep_halt;
  logic              timeout_flag_set, watchdog_clear, irq_vector_ok;
  logic [15:0]       pc_value, pmem_rdata, table_latch, table_pointer;
  logic [15:0]       s_pcv, lexp, pexp, w16, q[$];
  logic [7:0]        wexp, a;
  logic [12:0]       e;
  logic [6:0]        s_o;
  logic [2:0]        s_ic;
  logic [31:0]       seed = 32'd13622;
  int                n_errors = 0, samples_checked = 0, cyc = 0, s_cyc;
  localparam logic [6:0] HS [9] = '{CIRT_RRC_HI7, CIRT_RLC_HI7,
    CIRT_RRN_HI7, CIRT_RLN_HI7, CIRT_SWAP_HI7, CIRT_SETALL_HI7,
    CIRT_XORF_HI7, CIRT_SUBW_HI7, CIRT_SUBWB_HI7};

  // small on-chip top so the pointer reaches external memory quickly
  cirt_core #(.ONCHIP_TOP(16'h0003)) DUT (
    .clk(clk), .reset(reset), .insn_valid(insn_valid), .insn(insn),
    .insn_ready(insn_ready), .file_rdata(file_rdata), .file_wr(file_wr),
    .stack_top(stack_top), .cpu_status_reg(cpu_status_reg),
    .flags_in(flags_in), .pc_load(pc_load), .pc_value(pc_value),
    .stack_pop(stack_pop), .skip_next(skip_next), .flags_we(flags_we),
    .flags_out(flags_out), .clear_irq_disable(clear_irq_disable),
    .power_down_flag_clr(power_down_flag_clr), .sleep_halt(sleep_halt),
    .timeout_flag_set(timeout_flag_set), .watchdog_clear(watchdog_clear),
    .pmem(pmem), .pmem_rdata(pmem_rdata), .irq_flags(irq_flags),
    .irq_mask_en(irq_mask_en), .irq_flag_clr(irq_flag_clr),
    .irq_vector_ok(irq_vector_ok), .working_reg(working_reg),
    .table_latch(table_latch), .table_pointer(table_pointer));
  cirt_mem u_mem (.clk(clk), .faddr(insn[7:0]), .file_wr(file_wr),
    .file_rdata(file_rdata), .pmem(pmem), .pmem_rdata(pmem_rdata));

  initial forever #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
    samples_checked++;
    if (got !== ex) begin
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
      n_errors++;
    end
  endtask
  task end_sim();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // reference result: {flags, flags written, value}
  function automatic logic [12:0] ref_op(input logic [6:0] h,
      input logic [7:0] f, input logic [7:0] w, input cirt_flags_type c);
    logic [8:0] s;
    logic [4:0] n;
    logic       ci;
    ci = h == CIRT_SUBWB_HI7 ? c.c : 1'b1;  // carry set means no borrow
    s = {1'b0, f} + {1'b0, ~w} + 9'(ci);
    n = {1'b0, f[3:0]} + {1'b0, ~w[3:0]} + 5'(ci);
    case (h)
      CIRT_RRC_HI7: return {c[3:1], f[0], 1'b1, c.c, f[7:1]};
      CIRT_RLC_HI7: return {c[3:1], f[7], 1'b1, f[6:0], c.c};
      CIRT_RRN_HI7: return {c, 1'b0, f[0], f[7:1]};
      CIRT_RLN_HI7: return {c, 1'b0, f[6:0], f[7]};
      CIRT_SWAP_HI7: return {c, 1'b0, f[3:0], f[7:4]};
      CIRT_SETALL_HI7: return {c, 1'b0, CIRT_ALL_ONES};
      CIRT_XORF_HI7: return {c[3], (f ^ w) == 8'h00, c[1:0], 1'b1, f ^ w};
      default: return {(f[7] ^ w[7]) & (s[7] ^ f[7]), s[7:0] == 8'h00,
                       n[4], s[8], 1'b1, s[7:0]};
    endcase
  endfunction
  // issue one word after a falling edge, capture the answer at the taking
  // edge, then count cycles until ready returns (bounded by lim)
  task run(input logic [15:0] w, input int lim);
    @(negedge clk);
    insn = w;
    flags_in = fl;
    insn_valid = 1;
    @(posedge clk);
    s_o = {pc_load, stack_pop, clear_irq_disable, skip_next, flags_we,
           power_down_flag_clr, timeout_flag_set & watchdog_clear};
    s_fl = flags_out;
    s_pcv = pc_value;
    s_pm = pmem;
    @(negedge clk);
    insn_valid = 0;
    s_pm2 = pmem;
    s_ic = irq_flag_clr;
    s_cyc = 1;
    while (insn_ready !== 1'b1 && s_cyc < lim) begin
      @(negedge clk);
      s_cyc++;
    end
  endtask
  task alu_chk();
    chk("alu", {e[8], wexp, 8'd1}, {s_o[2], working_reg, 8'(s_cyc)});
    if (e[8]) chk("flags", e[12:9], s_fl);
  endtask
  task rst();
    @(negedge clk);
    reset = 1;
    repeat (20) @(negedge clk);
    reset = 0;
    wexp = CIRT_W_RST;
    lexp = CIRT_LATCH_RST;
    pexp = CIRT_PTR_RST;
    @(negedge clk);
    chk("reset", {wexp, lexp, pexp, 1'b1},
        {working_reg, table_latch, table_pointer, insn_ready});
  endtask
  ////////////////////////////////////////////////////////////////////////
  // watcher: every file write must match the oldest note
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      end_sim();
    end else if (!reset && file_wr.we === 1'b1) begin
      if (q.size() == 0) chk("stray write", 1, 0);
      else chk("file_wr", q.pop_front(), {file_wr.addr, file_wr.data});
    end
  end
  initial begin
    rst();
    run(CIRT_NOP_WORD, 4);
    chk("nop", {1'b0, wexp, 8'd1}, {s_o[2], working_reg, 8'(s_cyc)});
    // file ops, both destinations, random address, file and flags
    for (int j = 0; j < 18; j++) begin
      fl = 4'(rnd());
      a = 8'(rnd());
      e = ref_op(HS[j % 9], u_mem.mem[a], wexp, fl);
      if (j >= 9 || HS[j % 9] == CIRT_SETALL_HI7) q.push_back({a, e[7:0]});
      if (j < 9) wexp = e[7:0];
      run({HS[j % 9], 1'(j >= 9), a}, 4);
      alu_chk();
    end
    for (int k = 0; k < 2; k++) begin
      a = 8'(rnd());
      e = ref_op(k ? CIRT_XORF_HI7 : CIRT_SUBW_HI7, a, wexp, fl);
      wexp = e[7:0];
      run({k ? CIRT_XORLIT_HI8 : CIRT_SUBLIT_HI8, a}, 4);
      alu_chk();
    end
    for (int k = 0; k < 3; k++) begin
      stack_top = 16'(rnd());
      a = 8'(rnd());
      w16 = k == 0 ? CIRT_RETURN_WORD : CIRT_RETFIRQ_WORD;
      if (k == 2) wexp = a;
      run(k == 2 ? {CIRT_RETLIT_HI8, a} : w16, 4);
      chk("ret", {2'b11, k == 1, 1'b0, k == 1, stack_top, wexp, 8'd2},
          {s_o[6:4], s_o[2], s_o[4], s_pcv, working_reg,
          8'(s_cyc)});
    end
    u_mem.mem[8'h40] = 8'h00;
    u_mem.mem[8'h41] = 8'h01;  // random writes above may have hit it
    for (int k = 0; k < 2; k++) begin
      run({CIRT_TSTZ_HI8, 8'h41 - 8'(k)}, 4);
      chk("skip", {k[0], 1'b0}, s_o[3:2]);
    end
    for (int t = 0; t < 2; t++) begin
      a = 8'(rnd());
      if (t) lexp[15:8] = u_mem.mem[a];
      else lexp[7:0] = u_mem.mem[a];
      run({CIRT_LATWR_HI6, 1'(t), 1'b0, a}, 4);
      chk("latch put", {lexp, 8'd1}, {table_latch, 8'(s_cyc)});
      q.push_back({a + 8'h01, t ? lexp[15:8] : lexp[7:0]});
      run({CIRT_LATRD_HI6, 1'(t), 1'b1, a + 8'h01}, 4);
      chk("latch get", {lexp, 8'd1}, {table_latch, 8'(s_cyc)});
    end
    // five reads: the first four walk the pointer past on-chip, the fifth lands on pc low
    for (int k = 0; k < 5; k++) begin
      a = k == 4 ? CIRT_PCL_ADDR : 8'h50 + 8'(k);
      q.push_back({a, k[0] ? lexp[15:8] : lexp[7:0]});
      run({CIRT_TBLRD_HI6, k[0], 1'(k < 4), a}, 8);
      chk("rd addr", {1'b1, pexp}, {s_pm.rd, s_pm.addr});
      lexp = ~pexp;
      if (k < 4) pexp++;
      chk("tblrd", {lexp, pexp, k == 4 ? 8'd3 : 8'd2},
          {table_latch, table_pointer, 8'(s_cyc)});
    end
    a = 8'(rnd());
    lexp[15:8] = u_mem.mem[a];
    // an enabled pending irq is cleared by a short write as well
    irq_flags = 3'b011;
    irq_mask_en = 3'b010;
    run({CIRT_TBLWR_HI6, 2'b11, a}, 8);
    chk("tblwt", {1'b1, pexp, lexp, 8'd2, 3'b010},
        {s_pm2.wr, s_pm2.addr, s_pm2.data, 8'(s_cyc),
        s_ic});
    pexp++;
    chk("tblwt ptr", pexp, table_pointer);
    run(CIRT_SLEEP_WORD, 4);
    chk("sleep", 2'b11, {s_o[1] & s_o[0], sleep_halt});
    rst();
    // long writes: a masked pending irq must not end them
    for (int k = 0; k < 2; k++) begin
      cpu_status_reg = k ? 8'h00 : 8'h10;
      irq_flags = 3'b001;
      irq_mask_en = 3'b110;
      a = 8'(rnd());
      lexp[7:0] = u_mem.mem[a];
      run({CIRT_TBLWR_HI6, 2'b00, a}, 8);
      chk("long", {1'b1, pexp, lexp, 8'd8},
          {pmem.wr, pmem.addr, pmem.data, 8'(s_cyc)});
      irq_flags = 3'b101;
      @(posedge clk);
      chk("irq end", {3'b100, k[0]}, {irq_flag_clr, irq_vector_ok});
      @(negedge clk);
      irq_flags = 0;
      chk("long done", 1'b1, insn_ready);
    end
    chk("notes left", 0, q.size());
    end_sim();
  end
endmodule
